// ===== src/iop_ports.sv
// Top of the I/O port block: L, G, D and I ports behind an AXI4-Lite slave
// Assumes pins synchronous to clk_in; board resolves pin levels from enables
// Notes on behaviour
// - The L port has eight pins each with its own data and config bit.
// - Config/data 00 is floating input, 01 pulled-up input, 10 drives low, 11 drives high.
// - Each eight-bit port has a data, a config and a pin-read location.
// - The G port has bidirectional bits 0 to 5 and input-only bits 6 and 7.
// - G bits 0 to 5 use the same config and data encoding as the L port.
// - Writing one to config bits 6 or 7 of G has no effect; those pins stay inputs.
// - Config bits 6 and 7 of G always read zero.
// - Setting G data bit 7 puts the device into halt.
// - The G bit 7 pin is a normal input and also the continue input that ends halt.
// - G alternates: bit 0 interrupt in, 3 timer, 4 serial out, 5 serial clock, 6 serial in; the block has no serial out, so bit 4 stays plain.
// - G bits 1 and 2 are plain general-purpose pins only.
// - With the crystal option G bit 7 is the oscillator output, else input and restart.
// - The four-bit D output port is driven all high while reset is low.
// - The four-bit I input port is readable high-impedance inputs.
// - The instruction cycle is the input clock divided by ten.
//
// The register addresses and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "iop_defines.svh"
module iop_ports
    import iop_pkg::*;
#(
    parameter int DIV = `IOP_CLK_DIV,
    parameter bit CRYSTAL_OPT = 1'b0
) (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic [11:0] s_axi_awaddr_in,
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    output logic [1:0] s_axi_bresp_out,
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    input wire logic [11:0] s_axi_araddr_in,
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    output logic [31:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out,
    output logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    input wire logic [7:0] l_pin_in,
    output logic [7:0] l_pin_out,
    output logic [7:0] l_pin_oe_n_out,
    output logic [7:0] l_pull_up_out,
    input wire logic [7:0] g_pin_in,
    output logic [5:0] g_pin_out,
    output logic [5:0] g_pin_oe_n_out,
    output logic [5:0] g_pull_up_out,
    output logic [3:0] d_port_out,
    input wire logic [3:0] i_port_in,
    input wire logic osc_in,
    output logic oscillator_output_out,
    output logic external_interrupt_out,
    output logic timer_io_in_out,
    output logic serial_in_out,
    output logic serial_clock_in_out,
    output logic halt_out,
    output logic instr_tick_out
);
    iop_byte_t l_data_reg, l_cfg_reg, g_data_reg, g_cfg_reg;
    logic [3:0] d_reg;
    iop_mode_e mode_reg, mode_next;
    logic [3:0] div_reg;
    logic tick_reg;
    logic aw_full_reg, w_full_reg;
    logic [11:0] aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    logic bvalid_reg, rvalid_reg;
    logic [1:0] bresp_reg, rresp_reg;
    logic [31:0] rdata_reg;
    logic [7:0] l_level, g_level_raw;
    logic [7:0] g_level;
    logic [7:0] g_in_reg;
    logic [3:0] i_reg;
    logic [7:0] g_oe_full, g_pin_full, g_pull_full;

    function automatic logic [31:0] byte_word(input logic [7:0] b);
        byte_word = {24'h0000_00, b};
    endfunction : byte_word

    // Write channel capture, either order
    wire do_write = aw_full_reg && w_full_reg && !bvalid_reg;
    wire aw_take = s_axi_awvalid_in && !aw_full_reg;
    wire w_take = s_axi_wvalid_in && !w_full_reg;
    wire wr_l_data = do_write && aw_addr_reg == `IOP_OFF_L_DATA && w_strb_reg[0];
    wire wr_l_cfg = do_write && aw_addr_reg == `IOP_OFF_L_CFG && w_strb_reg[0];
    wire wr_g_data = do_write && aw_addr_reg == `IOP_OFF_G_DATA && w_strb_reg[0];
    wire wr_g_cfg = do_write && aw_addr_reg == `IOP_OFF_G_CFG && w_strb_reg[0];
    wire wr_d = do_write && aw_addr_reg == `IOP_OFF_D_DATA && w_strb_reg[0];
    wire wr_hit = aw_addr_reg == `IOP_OFF_L_DATA || aw_addr_reg == `IOP_OFF_L_CFG ||
                  aw_addr_reg == `IOP_OFF_G_DATA || aw_addr_reg == `IOP_OFF_G_CFG ||
                  aw_addr_reg == `IOP_OFF_D_DATA;
    wire [7:0] wbyte = w_data_reg[7:0];
    wire [7:0] g_cfg_masked = wbyte & ~`IOP_G_INPUT_ONLY;
    wire halt_set = wr_g_data && wbyte[`IOP_HALT_BIT];
    wire wake_pin = CRYSTAL_OPT ? 1'b0 : g_level[7];

    // Read decode
    wire rd_take = s_axi_arvalid_in && !rvalid_reg;
    wire [11:0] ra = s_axi_araddr_in;
    wire rd_hit = ra == `IOP_OFF_L_DATA || ra == `IOP_OFF_L_CFG || ra == `IOP_OFF_L_PIN ||
                  ra == `IOP_OFF_G_DATA || ra == `IOP_OFF_G_CFG || ra == `IOP_OFF_G_PIN ||
                  ra == `IOP_OFF_D_DATA || ra == `IOP_OFF_I_PIN || ra == `IOP_OFF_CTRL ||
                  ra == `IOP_OFF_STATUS;
    wire [31:0] rd_mux =
        ra == `IOP_OFF_L_DATA ? byte_word(l_data_reg) :
        ra == `IOP_OFF_L_CFG ? byte_word(l_cfg_reg) :
        ra == `IOP_OFF_L_PIN ? byte_word(l_level) :
        ra == `IOP_OFF_G_DATA ? byte_word(g_data_reg) :
        ra == `IOP_OFF_G_CFG ? byte_word(g_cfg_reg & ~`IOP_G_INPUT_ONLY) :
        ra == `IOP_OFF_G_PIN ? byte_word(g_level) :
        ra == `IOP_OFF_D_DATA ? {28'h000_0000, d_reg} :
        ra == `IOP_OFF_I_PIN ? {28'h000_0000, i_reg} :
        ra == `IOP_OFF_CTRL ? {31'h0000_0000, CRYSTAL_OPT} :
        ra == `IOP_OFF_STATUS ? {30'h0000_0000, mode_reg} : 32'h0000_0000;

    // Input-only G bits never drive
    assign g_level = {g_in_reg[7:6], g_level_raw[5:0]};

    iop_pin_cell #(.WIDTH(8)) u_l_cells (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .cfg_in(l_cfg_reg),
        .data_in(l_data_reg),
        .pin_in(l_pin_in),
        .pin_out(l_pin_out),
        .pin_oe_n_out(l_pin_oe_n_out),
        .pull_up_out(l_pull_up_out),
        .level_out(l_level)
    );
    iop_pin_cell #(.WIDTH(8)) u_g_cells (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .cfg_in(g_cfg_reg & ~`IOP_G_INPUT_ONLY),
        .data_in(g_data_reg),
        .pin_in(g_pin_in),
        .pin_out(g_pin_full),
        .pin_oe_n_out(g_oe_full),
        .pull_up_out(g_pull_full),
        .level_out(g_level_raw)
    );
    assign g_pin_out = g_pin_full[5:0];
    assign g_pin_oe_n_out = g_oe_full[5:0];
    assign g_pull_up_out = g_pull_full[5:0];

    // Halt mode sequencing
    always_comb begin
        mode_next = mode_reg;
        case (mode_reg)
            IOP_RUN: if (halt_set) mode_next = IOP_HALT;
            IOP_HALT: if (wake_pin) mode_next = IOP_WAKE;
            IOP_WAKE: mode_next = IOP_RUN;
            default: mode_next = IOP_RUN;
        endcase
    end

    // Port registers
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            l_data_reg <= `IOP_RST_PORT;
            l_cfg_reg <= `IOP_RST_PORT;
            g_data_reg <= `IOP_RST_PORT;
            g_cfg_reg <= `IOP_RST_PORT;
            d_reg <= `IOP_RST_D;
            mode_reg <= IOP_RUN;
        end else begin
            if (wr_l_data) l_data_reg <= wbyte;
            if (wr_l_cfg) l_cfg_reg <= wbyte;
            if (wr_g_cfg) g_cfg_reg <= g_cfg_masked;
            if (wr_g_data) g_data_reg <= wbyte;
            else if (mode_reg == IOP_WAKE) g_data_reg[`IOP_HALT_BIT] <= 1'b0;
            if (wr_d) d_reg <= wbyte[3:0];
            mode_reg <= mode_next;
        end
    end

    // Input sampling and alternate functions
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            g_in_reg <= 8'h00;
            i_reg <= 4'h0;
            d_port_out <= `IOP_RST_D;
            external_interrupt_out <= 1'b0;
            timer_io_in_out <= 1'b0;
            serial_in_out <= 1'b0;
            serial_clock_in_out <= 1'b0;
            oscillator_output_out <= 1'b0;
            halt_out <= 1'b0;
        end else begin
            g_in_reg <= g_pin_in;
            i_reg <= i_port_in;
            d_port_out <= d_reg;
            external_interrupt_out <= g_level[0];
            timer_io_in_out <= g_level[3];
            serial_clock_in_out <= g_level[5];
            serial_in_out <= g_level[6];
            oscillator_output_out <= CRYSTAL_OPT ? ~osc_in : 1'b0;
            halt_out <= mode_next == IOP_HALT;
        end
    end

    // Instruction cycle divider, stopped in halt
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            div_reg <= 4'h0;
            tick_reg <= 1'b0;
        end else if (mode_next == IOP_HALT) begin
            tick_reg <= 1'b0;
        end else begin
            tick_reg <= div_reg == 4'(DIV - 1);
            div_reg <= div_reg == 4'(DIV - 1) ? 4'h0 : div_reg + 4'h1;
        end
    end
    assign instr_tick_out = tick_reg;

    // AXI4-Lite write side
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            aw_full_reg <= 1'b0;
            w_full_reg <= 1'b0;
            aw_addr_reg <= 12'h000;
            w_data_reg <= 32'h0000_0000;
            w_strb_reg <= 4'h0;
            bvalid_reg <= 1'b0;
            bresp_reg <= `IOP_RESP_OKAY;
        end else begin
            if (aw_take) begin
                aw_full_reg <= 1'b1;
                aw_addr_reg <= {s_axi_awaddr_in[11:2], 2'b00};
            end
            if (w_take) begin
                w_full_reg <= 1'b1;
                w_data_reg <= s_axi_wdata_in;
                w_strb_reg <= s_axi_wstrb_in;
            end
            if (do_write) begin
                aw_full_reg <= 1'b0;
                w_full_reg <= 1'b0;
                bvalid_reg <= 1'b1;
                bresp_reg <= wr_hit ? `IOP_RESP_OKAY : `IOP_RESP_SLVERR;
            end else if (bvalid_reg && s_axi_bready_in) begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    // AXI4-Lite read side
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= `IOP_RESP_OKAY;
        end else if (rd_take) begin
            rvalid_reg <= 1'b1;
            rdata_reg <= rd_mux;
            rresp_reg <= rd_hit ? `IOP_RESP_OKAY : `IOP_RESP_SLVERR;
        end else if (rvalid_reg && s_axi_rready_in) begin
            rvalid_reg <= 1'b0;
        end
    end

    assign s_axi_awready_out = !aw_full_reg;
    assign s_axi_wready_out = !w_full_reg;
    assign s_axi_bvalid_out = bvalid_reg;
    assign s_axi_bresp_out = bresp_reg;
    assign s_axi_arready_out = !rvalid_reg;
    assign s_axi_rvalid_out = rvalid_reg;
    assign s_axi_rdata_out = rdata_reg;
    assign s_axi_rresp_out = rresp_reg;
endmodule : iop_ports
`default_nettype wire

// ===== src/iop_defines.svh
// Offsets, reset values and timing counts for the I/O port block
// Assumes inclusion by bare name from design files
`ifndef IOP_DEFINES_SVH
`define IOP_DEFINES_SVH
`define IOP_OFF_L_DATA 12'h000
`define IOP_OFF_L_CFG 12'h004
`define IOP_OFF_L_PIN 12'h008
`define IOP_OFF_G_DATA 12'h00C
`define IOP_OFF_G_CFG 12'h010
`define IOP_OFF_G_PIN 12'h014
`define IOP_OFF_D_DATA 12'h018
`define IOP_OFF_I_PIN 12'h01C
`define IOP_OFF_CTRL 12'h020
`define IOP_OFF_STATUS 12'h024
`define IOP_RST_PORT 8'h00
`define IOP_RST_D 4'hF
`define IOP_G_INPUT_ONLY 8'hC0
`define IOP_HALT_BIT 7
`define IOP_CLK_DIV 10
`define IOP_RESP_OKAY 2'b00
`define IOP_RESP_SLVERR 2'b10
`endif

// ===== src/iop_pkg.sv
// Types shared by the I/O port block
// Assumes nothing of its surroundings
package iop_pkg;
    typedef enum logic [1:0] {
        IOP_RUN = 2'b00,
        IOP_HALT = 2'b01,
        IOP_WAKE = 2'b11
    } iop_mode_e;
    typedef logic [7:0] iop_byte_t;
endpackage : iop_pkg

// ===== src/iop_pin_cell.sv
// One bidirectional port pin cell: config and data decode to drive and pull
// Assumes pin levels are synchronous to clk_in
`timescale 1ns/1ps
`default_nettype none
module iop_pin_cell #(
    parameter int WIDTH = 8
) (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic [WIDTH-1:0] cfg_in,
    input wire logic [WIDTH-1:0] data_in,
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] pin_out,
    output logic [WIDTH-1:0] pin_oe_n_out,
    output logic [WIDTH-1:0] pull_up_out,
    output logic [WIDTH-1:0] level_out
);
    logic [WIDTH-1:0] oe_n_next;
    logic [WIDTH-1:0] pull_next;
    // Config selects push-pull, data picks level or pull-up
    assign oe_n_next = ~cfg_in;
    assign pull_next = ~cfg_in & data_in;
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            pin_out <= '0;
            pin_oe_n_out <= '1;
            pull_up_out <= '0;
            level_out <= '0;
        end else begin
            pin_out <= data_in;
            pin_oe_n_out <= oe_n_next;
            pull_up_out <= pull_next;
            level_out <= pin_in;
        end
    end
endmodule : iop_pin_cell
`default_nettype wire

// ===== sim/iop_ports_monitor.sv
// Concurrent checks on the I/O port block top
// Assumes binding to iop_ports; pins resolved by the board
`timescale 1ns/1ps
`default_nettype none
module iop_ports_monitor #(
    parameter int DIV = 10,
    parameter bit CRYSTAL_OPT = 1'b0
) (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic [11:0] s_axi_araddr_in,
    input wire logic s_axi_arvalid_in,
    input wire logic s_axi_arready_out,
    input wire logic [31:0] s_axi_rdata_out,
    input wire logic [1:0] s_axi_rresp_out,
    input wire logic s_axi_rvalid_out,
    input wire logic [7:0] l_pin_oe_n_out,
    input wire logic [7:0] l_pull_up_out,
    input wire logic [7:0] g_pin_in,
    input wire logic [5:0] g_pin_oe_n_out,
    input wire logic [5:0] g_pull_up_out,
    input wire logic [3:0] d_port_out,
    input wire logic external_interrupt_out,
    input wire logic timer_io_in_out,
    input wire logic serial_in_out,
    input wire logic serial_clock_in_out,
    input wire logic halt_out,
    input wire logic instr_tick_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!nrst_in);
    logic [11:0] ar_q;
    always_ff @(posedge clk_in) begin
        if (s_axi_arvalid_in && s_axi_arready_out) ar_q <= s_axi_araddr_in;
    end
    a_reset_d_high: assert property (disable iff (1'b0) !nrst_in |=> d_port_out == 4'hF)
        else $error("D port not high in reset");
    a_reset_pins_float: assert property (disable iff (1'b0) !nrst_in |=>
        &l_pin_oe_n_out && &g_pin_oe_n_out && l_pull_up_out == 8'h00 && g_pull_up_out == 6'h00)
        else $error("Pins not floating in reset");
    a_drive_no_pull: assert property ((~l_pin_oe_n_out & l_pull_up_out) == 8'h00 &&
        (~g_pin_oe_n_out & g_pull_up_out) == 6'h00) else $error("Pull-up on while driving");
    a_halt_hold: assert property (halt_out && !$past(g_pin_in[7]) |=> halt_out) else $error("Halt left");
    a_halt_no_tick: assert property (halt_out |-> !instr_tick_out) else $error("Tick in halt");
    a_wake_exit: assert property (!CRYSTAL_OPT && halt_out && g_pin_in[7] |-> ##[1:3] !halt_out)
        else $error("Halt not left on continue pin");
    a_tick_gap: assert property (disable iff (!nrst_in || halt_out) instr_tick_out |=>
        (!instr_tick_out) [*8] ##1 !instr_tick_out ##1 instr_tick_out) else $error("Tick spacing wrong");
    a_alt_copy: assert property ($past(nrst_in) && $past(nrst_in, 2) |->
        {serial_in_out, serial_clock_in_out, timer_io_in_out, external_interrupt_out} ==
        {$past(g_pin_in[6], 2), $past(g_pin_in[5], 2), $past(g_pin_in[3], 2), $past(g_pin_in[0], 2)})
        else $error("Alternate input copy wrong");
    a_read_answer: assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
        else $error("Read not answered");
    a_cfg_top_zero: assert property (s_axi_rvalid_out && ar_q == 12'h010 |->
        s_axi_rdata_out[7:6] == 2'b00) else $error("Input-only config bits read nonzero");
    a_unmapped_err: assert property (s_axi_rvalid_out && ar_q > 12'h024 |->
        s_axi_rresp_out == 2'b10 && s_axi_rdata_out == 32'h0000_0000) else $error("Unmapped read");
endmodule : iop_ports_monitor
bind iop_ports iop_ports_monitor #(.DIV(DIV), .CRYSTAL_OPT(CRYSTAL_OPT)) u_mon (.clk_in, .nrst_in,
    .s_axi_araddr_in, .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rdata_out, .s_axi_rresp_out,
    .s_axi_rvalid_out, .l_pin_oe_n_out, .l_pull_up_out, .g_pin_in, .g_pin_oe_n_out, .g_pull_up_out,
    .d_port_out, .external_interrupt_out, .timer_io_in_out, .serial_in_out, .serial_clock_in_out,
    .halt_out, .instr_tick_out);
`default_nettype wire

// ===== sim/iop_board.sv
// Board model of eight port pins: drivers, pull-ups, external sources
// Assumes enables low while the block drives a pin
`timescale 1ns/1ps
`default_nettype none
module iop_board (
    input wire logic clk_in,
    input wire logic [7:0] drv_in,
    input wire logic [7:0] oe_n_in,
    input wire logic [7:0] pull_in,
    input wire logic [7:0] ext_in,
    input wire logic [7:0] ext_en_in,
    output logic [7:0] lvl_out
);
    logic [7:0] last_reg = 8'h00;
    // Block drive wins, then board source, then pull-up, else drifting
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            lvl_out[i] = !oe_n_in[i] ? drv_in[i] : ext_en_in[i] ? ext_in[i] : pull_in[i] ? 1'b1 : ~last_reg[i];
        end
    end
    always_ff @(posedge clk_in) begin
        last_reg <= lvl_out;
    end
endmodule : iop_board
`default_nettype wire

// ===== sim/tb_iop_ports.sv
// Self-checking bench of the I/O port block over AXI4-Lite
// Assumes default DIV and CRYSTAL_OPT; board models resolve pins
`timescale 1ns/1ps
`default_nettype none
module tb_iop_ports;
    logic clk_in = 1'b0, nrst_in = 1'b0, osc_in = 1'b0;
    logic [11:0] s_axi_awaddr_in = 12'h000, s_axi_araddr_in = 12'h000;
    logic [31:0] s_axi_wdata_in = 32'h0000_0000, s_axi_rdata_out, seed = 32'h3d0e_bd3e, r;
    logic [3:0] s_axi_wstrb_in = 4'hF, i_port_in = 4'h0, d_port_out;
    logic s_axi_awvalid_in = 1'b0, s_axi_wvalid_in = 1'b0, s_axi_bready_in = 1'b0;
    logic s_axi_arvalid_in = 1'b0, s_axi_rready_in = 1'b0;
    logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out, s_axi_rvalid_out;
    logic [1:0] s_axi_bresp_out, s_axi_rresp_out;
    logic [7:0] l_pin_out, l_pin_oe_n_out, l_pull_up_out, l_ext = 8'h00, l_en = 8'h00, g_ext = 8'h00;
    logic [7:0] g_en = 8'hC0;
    logic [5:0] g_pin_out, g_pin_oe_n_out, g_pull_up_out;
    logic oscillator_output_out, external_interrupt_out, timer_io_in_out, serial_in_out;
    logic serial_clock_in_out, halt_out, instr_tick_out;
    wire [7:0] l_pin_in, g_pin_in;
    logic [31:0] exp_q[$];
    logic [1:0] rsp_q[$];
    int fails = 0, tests_run = 0, n;
    iop_ports dut_u (.clk_in, .nrst_in, .s_axi_awaddr_in, .s_axi_awvalid_in, .s_axi_awready_out,
        .s_axi_wdata_in, .s_axi_wstrb_in, .s_axi_wvalid_in, .s_axi_wready_out, .s_axi_bresp_out,
        .s_axi_bvalid_out, .s_axi_bready_in, .s_axi_araddr_in, .s_axi_arvalid_in, .s_axi_arready_out,
        .s_axi_rdata_out, .s_axi_rresp_out, .s_axi_rvalid_out, .s_axi_rready_in, .l_pin_in, .l_pin_out,
        .l_pin_oe_n_out, .l_pull_up_out, .g_pin_in, .g_pin_out, .g_pin_oe_n_out, .g_pull_up_out,
        .d_port_out, .i_port_in, .osc_in, .oscillator_output_out, .external_interrupt_out,
        .timer_io_in_out, .serial_in_out, .serial_clock_in_out, .halt_out, .instr_tick_out);
    iop_board l_brd (.clk_in, .drv_in(l_pin_out), .oe_n_in(l_pin_oe_n_out), .pull_in(l_pull_up_out),
        .ext_in(l_ext), .ext_en_in(l_en), .lvl_out(l_pin_in));
    iop_board g_brd (.clk_in, .drv_in({2'b00, g_pin_out}), .oe_n_in({2'b11, g_pin_oe_n_out}),
        .pull_in({2'b00, g_pull_up_out}), .ext_in(g_ext), .ext_en_in(g_en), .lvl_out(g_pin_in));
    initial begin
        forever #4 clk_in = ~clk_in;
    end
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    task automatic complete_run();
        $display("Counts: %0d compared, %0d mismatched", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : complete_run
    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] s);
        tests_run++;
        if (s !== e) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, s);
        end
    endtask : chk
    task automatic axw(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge clk_in);
        s_axi_awaddr_in <= a;
        s_axi_wdata_in <= d;
        s_axi_awvalid_in <= 1'b1;
        s_axi_wvalid_in <= 1'b1;
        s_axi_bready_in <= 1'b1;
        for (int k = 0; k < 60 && s_axi_bvalid_out !== 1'b1; k++) begin
            @(posedge clk_in);
            if (s_axi_awready_out) s_axi_awvalid_in <= 1'b0;
            if (s_axi_wready_out) s_axi_wvalid_in <= 1'b0;
        end
        if (s_axi_bvalid_out !== 1'b1) begin
            fails++;
            complete_run();
        end
        s_axi_bready_in <= 1'b0;
        chk("bresp", er, s_axi_bresp_out);
    endtask : axw
    task automatic axr(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
        @(posedge clk_in);
        exp_q.push_back(e);
        rsp_q.push_back(er);
        s_axi_araddr_in <= a;
        s_axi_arvalid_in <= 1'b1;
        s_axi_rready_in <= 1'b1;
        for (int k = 0; k < 60 && s_axi_rvalid_out !== 1'b1; k++) begin
            @(posedge clk_in);
            if (s_axi_arready_out) s_axi_arvalid_in <= 1'b0;
        end
        if (s_axi_rvalid_out !== 1'b1) begin
            fails++;
            complete_run();
        end
        s_axi_rready_in <= 1'b0;
    endtask : axr
    always @(posedge clk_in) begin
        if (s_axi_rvalid_out && s_axi_rready_in) begin
            chk("rdata", exp_q.pop_front(), s_axi_rdata_out);
            chk("rresp", rsp_q.pop_front(), s_axi_rresp_out);
        end
    end
    task automatic pin_case(input bit g, input logic [7:0] c, input logic [7:0] d);
        logic [7:0] m, cfg, dd, lvl;
        logic [11:0] b;
        m = g ? 8'h3F : 8'hFF;
        cfg = c & m;
        dd = d & m;
        r = rnd();
        lvl = dd | (~cfg & r[7:0]);
        b = g ? 12'h00C : 12'h000;
        if (g) g_ext <= r[7:0];
        if (g) g_en <= ~cfg & ~dd;
        else l_ext <= r[7:0];
        if (!g) l_en <= ~cfg & ~dd;
        axw(b + 12'h004, {24'h0, c}, 2'b00);
        axw(b, {24'h0, dd}, 2'b00);
        repeat (3) @(posedge clk_in);
        chk("oe_n", ~cfg & m, g ? {2'b00, g_pin_oe_n_out} : l_pin_oe_n_out);
        chk("pull", ~cfg & dd & m, g ? {2'b00, g_pull_up_out} : l_pull_up_out);
        axr(b + 12'h004, {24'h0, cfg}, 2'b00);
        axr(b + 12'h008, {24'h0, lvl}, 2'b00);
        axr(b, {24'h0, dd}, 2'b00);
        if (g) chk("alt", {lvl[6], lvl[5], lvl[3], lvl[0]},
            {serial_in_out, serial_clock_in_out, timer_io_in_out, external_interrupt_out});
    endtask : pin_case
    task automatic count_ticks(input int len, input int e);
        n = 0;
        repeat (len) begin
            @(posedge clk_in);
            n += instr_tick_out;
        end
        chk("ticks", e, n);
    endtask : count_ticks
    initial begin
        repeat (20) @(posedge clk_in);
        chk("d_reset", 4'hF, d_port_out);
        chk("l_oe_reset", 8'hFF, l_pin_oe_n_out);
        nrst_in <= 1'b1;
        axr(12'h000, 0, 2'b00);
        axr(12'h010, 0, 2'b00);
        axr(12'h018, 32'hF, 2'b00);
        axr(12'h020, 0, 2'b00);
        axr(12'h030, 0, 2'b10);
        axw(12'h030, 32'h1, 2'b10);
        $display("test reset_map done");
        pin_case(1'b0, 8'hCC, 8'hAA);
        pin_case(1'b1, 8'hCC, 8'hAA);
        for (int i = 0; i < 6; i++) begin
            r = rnd();
            pin_case(i[0], r[7:0], r[15:8]);
        end
        $display("test pin_modes done");
        r = rnd();
        i_port_in <= r[3:0];
        osc_in <= 1'b1;
        axw(12'h018, {28'h0, r[7:4]}, 2'b00);
        repeat (2) @(posedge clk_in);
        chk("d_port", r[7:4], d_port_out);
        chk("osc_out", 1'b0, oscillator_output_out);
        axr(12'h01C, {28'h0, r[3:0]}, 2'b00);
        count_ticks(100, 10);
        $display("test ports_ticks done");
        g_en <= 8'hFF;
        g_ext <= 8'h00;
        axw(12'h00C, 32'h80, 2'b00);
        repeat (3) @(posedge clk_in);
        chk("halt", 1, halt_out);
        axr(12'h024, 32'h1, 2'b00);
        count_ticks(30, 0);
        g_ext <= 8'h80;
        repeat (5) @(posedge clk_in);
        chk("wake", 0, halt_out);
        g_ext <= 8'h00;
        axr(12'h00C, 0, 2'b00);
        $display("test halt done");
        nrst_in <= 1'b0;
        repeat (3) @(posedge clk_in);
        chk("d_rst2", 4'hF, d_port_out);
        chk("l_oe_rst2", 8'hFF, l_pin_oe_n_out);
        nrst_in <= 1'b1;
        axr(12'h004, 0, 2'b00);
        repeat (2) @(posedge clk_in);
        $display("test second_reset done");
        complete_run();
    end
endmodule : tb_iop_ports
`default_nettype wire
